// ---- otp_host.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "otp_map.svh"
module otp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = `OTP_FIFO_DEPTH
) (
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW:0] cnt;
    logic [AW-1:0] rp;
    logic [AW-1:0] wp;
    logic rdy;
  } otp_fifo_s;
  otp_fifo_s q, d;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push, pop;

  assign push = in_valid_i & q.rdy;
  assign pop = out_valid_o & out_ready_i;
  assign out_valid_o = (q.cnt != '0);
  assign out_data_o = mem[q.rp];
  assign in_ready_o = q.rdy;

  always_comb begin
    d = q;
    if (push) begin
      d.wp = q.wp + 1'b1;
    end
    if (pop) begin
      d.rp = q.rp + 1'b1;
    end
    d.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
    d.rdy = d.cnt < (AW+1)'(DEPTH);
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      q <= '0;
      q.rdy <= 1'b1;
    end else begin
      q <= d;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (push) begin
      mem[q.wp] <= in_data_i;
    end
  end
endmodule

module otp_host #(
  parameter int PU_CYCLES = `OTP_PU_CYCLES,
  parameter int HALF = `OTP_SCLK_HALF
) (
  input wire logic core_clk_i,
  input wire logic srst_i,
  otp_spi_if.host link,
  input wire logic cmd_valid_i,
  output logic cmd_ready_o,
  input wire otp_pkg::otp_op_e cmd_op_i,
  input wire logic [23:0] cmd_addr_i,
  input wire logic [8:0] cmd_len_i,
  input wire logic wr_valid_i,
  output logic wr_ready_o,
  input wire logic [7:0] wr_data_i,
  output logic rd_valid_o,
  output logic [7:0] rd_data_o,
  output logic done_o
);
  import otp_pkg::*;
  otp_host_s q, d;
  logic f_valid, f_pop;
  logic [7:0] f_data, src;
  logic [11:0] len1;
  logic need;

  otp_fifo #(.WIDTH(8), .DEPTH(`OTP_FIFO_DEPTH)) u_fifo (
    .core_clk_i(core_clk_i),
    .srst_i(srst_i),
    .in_valid_i(wr_valid_i),
    .in_ready_o(wr_ready_o),
    .in_data_i(wr_data_i),
    .out_valid_o(f_valid),
    .out_ready_i(f_pop),
    .out_data_o(f_data)
  );

  always_comb begin
    d = q;
    f_pop = 1'b0;
    d.rd_valid = 1'b0;
    d.done = 1'b0;
    d.mi_sy = {q.mi_sy[0], link.miso};
    // one to 256 bytes per frame
    len1 = (cmd_len_i == 9'h0) ? 12'h001 :
           (cmd_len_i > 9'h100) ? 12'h100 : {3'h0, cmd_len_i};
    need = (q.op == OTP_OP_PROG) && !q.enable_first &&
           (q.bitn[11:3] >= 9'h004);
    case (q.bitn[11:3])
      9'h000: begin
        if (q.enable_first || q.op == OTP_OP_WR_ENABLE) begin
          src = `OTP_CMD_WR_ENABLE;
        end else if (q.op == OTP_OP_PROG) begin
          src = `OTP_CMD_PROG;
        end else if (q.op == OTP_OP_READ) begin
          src = `OTP_CMD_READ;
        end else begin
          src = `OTP_CMD_RDSR;
        end
      end
      9'h001: src = q.addr[23:16];
      9'h002: src = q.addr[15:8];
      9'h003: src = q.addr[7:0];
      default: src = need ? f_data : 8'h00;
    endcase
    if (!q.pu_done) begin
      d.pu_cnt = q.pu_cnt + 32'h1;
      d.pu_done = (q.pu_cnt == 32'(PU_CYCLES - 1));
    end
    case (q.st)
      H_IDLE: begin
        if (cmd_valid_i && q.rdy) begin
          d.op = cmd_op_i;
          d.bitn = 12'h0;
          d.div = 8'h0;
          d.cs_n = 1'b0;
          d.st = H_LOW;
          d.dstart = 12'hfff;
          d.enable_first = (cmd_op_i == OTP_OP_PROG);
          d.ptot = 12'd32 + {len1[8:0], 3'h0};
          d.addr = {14'h0, cmd_addr_i[9:0]};
          case (cmd_op_i)
            OTP_OP_READ: begin
              d.total = 12'd40 + {len1[8:0], 3'h0};
              d.dstart = 12'd40;
              d.addr = {14'h0, cmd_addr_i[9:0]};
            end
            OTP_OP_STATUS: begin
              d.total = 12'd8 + {len1[8:0], 3'h0};
              d.dstart = 12'd8;
            end
            default: d.total = 12'd8;
          endcase
        end
      end
      H_LOW: begin
        if (q.div == 8'h0) begin
          if (!(q.bitn[2:0] == 3'h0 && need && !f_valid)) begin
            if (q.bitn[2:0] == 3'h0) begin
              f_pop = need;
              d.mosi = src[7];
              d.sh = {src[6:0], 1'b0};
            end else begin
              d.mosi = q.sh[7];
              d.sh = {q.sh[6:0], 1'b0};
            end
            d.div = 8'h1;
          end
        end else if (q.div == 8'(HALF - 1)) begin
          d.div = 8'h0;
          d.sclk = 1'b1;
          d.st = H_HIGH;
        end else begin
          d.div = q.div + 8'h1;
        end
      end
      H_HIGH: begin
        if (q.div == 8'(HALF - 1)) begin
          d.div = 8'h0;
          d.sclk = 1'b0;
          if (q.bitn >= q.dstart) begin
            d.rx = {q.rx[6:0], q.mi_sy[1]};
            if (q.bitn[2:0] == 3'h7) begin
              d.rd_valid = 1'b1;
              d.rd_data = {q.rx[6:0], q.mi_sy[1]};
            end
          end
          if (q.bitn == q.total - 12'h1) begin
            d.st = H_TAIL;
          end else begin
            d.bitn = q.bitn + 12'h1;
            d.st = H_LOW;
          end
        end else begin
          d.div = q.div + 8'h1;
        end
      end
      H_TAIL, H_GAP: begin
        if (q.div == 8'(HALF - 1)) begin
          d.div = 8'h0;
          d.cs_n = 1'b1;
          d.st = (q.st == H_TAIL) ? H_GAP : H_IDLE;
          if (q.st == H_GAP && q.enable_first) begin
            d.enable_first = 1'b0;
            d.total = q.ptot;
            d.bitn = 12'h0;
            d.cs_n = 1'b0;
            d.st = H_LOW;
          end else if (q.st == H_GAP) begin
            d.done = 1'b1;
          end
        end else begin
          d.div = q.div + 8'h1;
        end
      end
      default: d.st = H_IDLE;
    endcase
    d.rdy = (d.st == H_IDLE) && d.pu_done;
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      q <= '0;
      q.cs_n <= 1'b1;
      q.st <= H_IDLE;
      q.dstart <= 12'hfff;
    end else begin
      q <= d;
    end
  end

  assign cmd_ready_o = q.rdy;
  assign rd_valid_o = q.rd_valid;
  assign rd_data_o = q.rd_data;
  assign done_o = q.done;
  assign link.cs_n = q.cs_n;
  assign link.sclk = q.sclk;
  assign link.mosi = q.mosi;
endmodule
`default_nettype wire

// ---- otp_map.svh ----
`ifndef OTP_MAP_SVH
`define OTP_MAP_SVH
`define OTP_CMD_WR_ENABLE 8'h06
`define OTP_CMD_WRDI 8'h04
`define OTP_CMD_RDSR 8'h05
`define OTP_CMD_PROG 8'h42
`define OTP_CMD_READ 8'h48
`define OTP_ERASED 8'hff
`define OTP_ST_BUSY 0
`define OTP_ST_LATCH 1
`define OTP_ST_LOCK 2
`define OTP_REG_NUM 4
`define OTP_REG_BYTES 256
`define OTP_CLK_MHZ 40
`define OTP_PROG_TIME_US 2400
`define OTP_PROG_CYCLES (`OTP_PROG_TIME_US * `OTP_CLK_MHZ)
`define OTP_PU_DELAY_US 10000
`define OTP_PU_CYCLES (`OTP_PU_DELAY_US * `OTP_CLK_MHZ)
`define OTP_SCLK_HALF 4
`define OTP_FIFO_DEPTH 32
`endif

// ---- otp_pkg.sv ----
package otp_pkg;
  typedef enum logic [1:0] {
    OTP_OP_WR_ENABLE, OTP_OP_PROG, OTP_OP_READ, OTP_OP_STATUS
  } otp_op_e;
  typedef enum logic [2:0] {
    D_CMD, D_ADDR, D_DUMMY, D_DIN, D_DOUT, D_STAT, D_END, D_IGN
  } otp_dev_st_e;
  typedef enum logic [2:0] {
    H_IDLE, H_LOW, H_HIGH, H_TAIL, H_GAP
  } otp_host_st_e;
  typedef struct packed {
    logic [2:0] cs_sy;
    logic [2:0] ck_sy;
    logic [1:0] si_sy;
    otp_dev_st_e st;
    logic [7:0] sh;
    logic [2:0] bc;
    logic [2:0] oc;
    logic [1:0] ac;
    logic [7:0] cmd;
    logic [23:0] addr;
    logic [7:0] tx;
    logic got;
    logic [255:0] mask;
    logic latch;
    logic busy;
    logic [31:0] tmr;
    logic [8:0] walk;
    logic [1:0] preg;
    logic so;
    logic so_oe_n;
  } otp_dev_s;
  typedef struct packed {
    logic [31:0] pu_cnt;
    logic pu_done;
    logic rdy;
    otp_host_st_e st;
    otp_op_e op;
    logic enable_first;
    logic [7:0] div;
    logic [11:0] bitn;
    logic [11:0] total;
    logic [11:0] ptot;
    logic [11:0] dstart;
    logic [23:0] addr;
    logic [7:0] sh;
    logic [7:0] rx;
    logic cs_n;
    logic sclk;
    logic mosi;
    logic rd_valid;
    logic [7:0] rd_data;
    logic done;
    logic [1:0] mi_sy;
  } otp_host_s;
endpackage

// ---- otp_spi_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface otp_spi_if;
  logic cs_n;
  logic sclk;
  logic mosi;
  logic miso;
  logic miso_oe_n;
  modport dev (input cs_n, sclk, mosi, output miso, miso_oe_n);
  modport host (output cs_n, sclk, mosi, input miso, miso_oe_n);
endinterface
`default_nettype wire

// ---- otp_dev.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "otp_map.svh"
// Behaviour
// - program frame takes 1 to 256 bytes
// - host sends write enable before program
// - program frame: 42H, address, data bytes
// - frame end starts timed program cycle
// - busy flag high during cycle, status readable
// - write latch cleared during program cycle
// - lock bit set ignores program command
// - program address: 00H, register 0-3, byte
// - read 48H, address, dummy, rising sampling
// - read data shifted out on falling edge
// - read starts anywhere, address increments
// - ten-bit address wraps 3FFH to 000H
// - read address upper bits must be zero
// - erased bytes FFH, status 00H
// - host waits power-up delay before writes
// - four separate 256-byte security registers
module otp_dev #(
  parameter int PROG_CYCLES = `OTP_PROG_CYCLES
) (
  input wire logic core_clk_i,
  input wire logic srst_i,
  otp_spi_if.dev link,
  input wire logic secure_lock_bit_i,
  output logic busy_flag_o,
  output logic write_latch_flag_o
);
  import otp_pkg::*;
  localparam int MEM_N = `OTP_REG_NUM * `OTP_REG_BYTES;
  otp_dev_s q, d;
  // four registers apart from main array
  logic [7:0] mem [MEM_N];
  logic [7:0] pbuf [`OTP_REG_BYTES];
  logic cs_hi, cs_rise, ck_rise, ck_fall, si;
  logic [7:0] byt, obyt, status, mem_rd, pbuf_rd;
  logic pwe, mwe;
  logic [7:0] pidx, pdat;
  logic [9:0] midx;

  assign mem_rd = mem[q.addr[9:0]];
  assign pbuf_rd = pbuf[q.walk[7:0]];
  assign midx = {q.preg, q.walk[7:0]};

  always_comb begin
    d = q;
    pwe = 1'b0;
    mwe = 1'b0;
    pidx = q.addr[7:0];
    pdat = 8'h00;
    byt = {q.sh[6:0], q.si_sy[1]};
    obyt = q.tx;
    status = 8'h00;
    status[`OTP_ST_BUSY] = q.busy;
    status[`OTP_ST_LATCH] = q.latch;
    status[`OTP_ST_LOCK] = secure_lock_bit_i;
    d.cs_sy = {q.cs_sy[1:0], link.cs_n};
    d.ck_sy = {q.ck_sy[1:0], link.sclk};
    d.si_sy = {q.si_sy[0], link.mosi};
    cs_hi = q.cs_sy[1];
    cs_rise = q.cs_sy[1] & ~q.cs_sy[2];
    ck_rise = q.ck_sy[1] & ~q.ck_sy[2];
    ck_fall = ~q.ck_sy[1] & q.ck_sy[2];
    si = q.si_sy[1];
    // busy for the whole timed cycle
    if (q.busy) begin
      if (q.walk < 9'h100) begin
        mwe = q.mask[q.walk[7:0]];
        d.walk = q.walk + 9'h001;
      end
      if (q.tmr == 32'h0) begin
        d.busy = 1'b0;
      end else begin
        d.tmr = q.tmr - 32'h1;
      end
    end
    if (cs_hi) begin
      d.st = D_CMD;
      d.bc = 3'h0;
      d.oc = 3'h0;
      d.so_oe_n = 1'b1;
      if (cs_rise && q.bc == 3'h0) begin
        if (q.st == D_END && q.cmd == `OTP_CMD_WR_ENABLE) begin
          d.latch = 1'b1;
        end
        if (q.st == D_END && q.cmd == `OTP_CMD_WRDI) begin
          d.latch = 1'b0;
        end
        // start cycle on a valid frame end
        // latch must be set to program
        // at least one data byte taken
        if (q.st == D_DIN && q.got && q.latch &&
            !secure_lock_bit_i) begin
          d.busy = 1'b1;
          d.latch = 1'b0;
          d.tmr = 32'(PROG_CYCLES - 1);
          d.walk = 9'h000;
          d.preg = q.addr[9:8];
        end
      end
    end else begin
      if (ck_rise) begin
        d.sh = {q.sh[6:0], si};
        d.bc = q.bc + 3'h1;
        if (q.bc == 3'h7) begin
          case (q.st)
            D_CMD: begin
              d.cmd = byt;
              d.ac = 2'h0;
              d.got = 1'b0;
              d.mask = '0;
              case (byt)
                `OTP_CMD_WR_ENABLE, `OTP_CMD_WRDI:
                  d.st = q.busy ? D_IGN : D_END;
                `OTP_CMD_RDSR: d.st = D_STAT;
                `OTP_CMD_PROG, `OTP_CMD_READ:
                  d.st = q.busy ? D_IGN : D_ADDR;
                default: d.st = D_IGN;
              endcase
            end
            D_ADDR: begin
              d.addr = {q.addr[15:0], byt};
              d.ac = q.ac + 2'h1;
              if (q.ac == 2'h2) begin
                if (q.cmd == `OTP_CMD_READ) begin
                  d.st = D_DUMMY;
                end else if (q.addr[15:8] == 8'h0 &&
                             q.addr[7:2] == 6'h0) begin
                  d.st = D_DIN;
                end else begin
                  d.st = D_IGN;
                end
              end
            end
            D_DUMMY: begin
              d.st = (q.addr[23:10] == 14'h0) ? D_DOUT : D_IGN;
            end
            D_DIN: begin
              pwe = 1'b1;
              pdat = byt;
              d.mask[q.addr[7:0]] = 1'b1;
              d.got = 1'b1;
              // extra bytes wrap in the page
              d.addr[7:0] = q.addr[7:0] + 8'h01;
            end
            D_END: d.st = D_IGN;
            default: d.st = q.st;
          endcase
        end
      end
      if (ck_fall && (q.st == D_DOUT || q.st == D_STAT)) begin
        if (q.oc == 3'h0) begin
          obyt = (q.st == D_STAT) ? status : mem_rd;
        end
        d.so_oe_n = 1'b0;
        d.so = obyt[7];
        d.tx = {obyt[6:0], 1'b0};
        d.oc = q.oc + 3'h1;
        if (q.oc == 3'h7 && q.st == D_DOUT) begin
          d.addr[9:0] = q.addr[9:0] + 10'h001;
        end
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      q <= '0;
      q.cs_sy <= 3'h7;
      q.st <= D_CMD;
      q.so_oe_n <= 1'b1;
    end else begin
      q <= d;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      for (int i = 0; i < MEM_N; i++) begin
        mem[i] <= `OTP_ERASED;
      end
    end else if (mwe) begin
      mem[midx] <= mem[midx] & pbuf_rd;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (pwe) begin
      pbuf[pidx] <= pdat;
    end
  end

  assign busy_flag_o = q.busy;
  assign write_latch_flag_o = q.latch;
  assign link.miso = q.so;
  assign link.miso_oe_n = q.so_oe_n;
endmodule
`default_nettype wire

// ---- otp_link_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
module otp_link_assertions #(
  parameter int PROG_CYCLES = 300
) (
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic mosi,
  input wire logic miso,
  input wire logic miso_oe_n,
  input wire logic secure_lock_bit_i,
  input wire logic busy_flag_o,
  input wire logic write_latch_flag_o
);
  logic [31:0] busy_cnt_q;
  logic [31:0] busy_cnt_d;

  // Length of the current busy stretch
  always_comb begin
    busy_cnt_d = busy_flag_o ? busy_cnt_q + 32'h1 : 32'h0;
  end

  always_ff @(posedge core_clk_i) begin
    busy_cnt_q <= srst_i ? 32'h0 : busy_cnt_d;
  end

  default clocking dclk @(posedge core_clk_i); endclocking
  default disable iff (srst_i);

  sclk_idle_a: assert property (
    cs_n |-> !sclk) else $error("serial clock high while deselected");
  cs_gap_a: assert property (
    $rose(cs_n) |-> cs_n [*4]) else $error("chip select gap too short");
  sclk_phase_a: assert property (
    $rose(sclk) |-> sclk [*4]) else $error("serial clock high too short");
  mosi_hold_a: assert property (
    sclk |-> $stable(mosi)) else $error("host data moved while clock high");
  miso_hold_a: assert property (
    sclk && $past(sclk) && $past(sclk, 2) && !miso_oe_n |-> $stable(miso))
    else $error("device data moved while clock high");
  oe_release_a: assert property (
    cs_n [*6] |-> miso_oe_n) else $error("output still driven");
  busy_entry_a: assert property (
    $rose(busy_flag_o) |-> cs_n && !secure_lock_bit_i &&
      $past(write_latch_flag_o)) else $error("bad program start");
  busy_latch_a: assert property (
    busy_flag_o |=> !write_latch_flag_o) else $error("latch set while busy");
  busy_length_a: assert property (
    $fell(busy_flag_o) |-> busy_cnt_q >= PROG_CYCLES - 1 &&
      busy_cnt_q <= PROG_CYCLES + 1) else $error("program cycle length");
  busy_cap_a: assert property (
    busy_cnt_q <= PROG_CYCLES + 1) else $error("program cycle too long");

  cover property ($rose(busy_flag_o));
  cover property ($fell(miso_oe_n));
  cover property ($rose(cs_n) && busy_flag_o);
endmodule
`default_nettype wire

// ---- secure_otp_region_access_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`define TB_CHK(got, exp) \
  begin n_tests++; if ((got) !== (exp)) begin fail_count++; \
  $display("mismatch at %0t: got %0h exp %0h", $time, got, exp); end end
module secure_otp_region_access_tb_top;
  import otp_pkg::*;
  localparam int PROG_CYCLES = 300;
  localparam int PU_CYCLES = 20;
  localparam int LIM = 20000;
  logic clk = 1'b0;
  logic srst, cmd_valid, cmd_ready, wr_valid, wr_ready, rd_valid, done;
  logic lock, busy, latch;
  otp_op_e cmd_op;
  logic [23:0] cmd_addr;
  logic [8:0] cmd_len;
  logic [7:0] wr_data, rd_data;
  int fail_count = 0;
  int n_tests = 0;
  logic [7:0] mem [1024];
  logic [7:0] rx_q [$];

  otp_spi_if link();
  otp_host #(.PU_CYCLES(PU_CYCLES), .HALF(4)) otp_host_inst (
    .core_clk_i(clk), .srst_i(srst), .link(link),
    .cmd_valid_i(cmd_valid), .cmd_ready_o(cmd_ready), .cmd_op_i(cmd_op),
    .cmd_addr_i(cmd_addr), .cmd_len_i(cmd_len), .wr_valid_i(wr_valid),
    .wr_ready_o(wr_ready), .wr_data_i(wr_data), .rd_valid_o(rd_valid),
    .rd_data_o(rd_data), .done_o(done));
  otp_dev #(.PROG_CYCLES(PROG_CYCLES)) otp_dev_inst (
    .core_clk_i(clk), .srst_i(srst), .link(link),
    .secure_lock_bit_i(lock), .busy_flag_o(busy),
    .write_latch_flag_o(latch));
  otp_link_assertions #(.PROG_CYCLES(PROG_CYCLES)) otp_link_assertions_inst (
    .core_clk_i(clk), .srst_i(srst), .cs_n(link.cs_n), .sclk(link.sclk),
    .mosi(link.mosi), .miso(link.miso), .miso_oe_n(link.miso_oe_n),
    .secure_lock_bit_i(lock), .busy_flag_o(busy),
    .write_latch_flag_o(latch));

  always #12.5 clk = ~clk;

  function automatic logic [7:0] pat(input int i);
    return 8'h5a ^ 8'(i * 37);
  endfunction

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic timeout();
    fail_count++;
    $display("mismatch at %0t: wait ran out", $time);
    end_of_test();
  endtask

  task automatic push_many(input int base, input int n);
    int k;
    for (int i = 0; i < n; i++) begin
      wr_valid = 1'b1;
      wr_data = pat(base + i);
      k = 0;
      while (wr_ready !== 1'b1 && k < LIM) begin
        @(negedge clk);
        k++;
      end
      if (k >= LIM) timeout();
      @(negedge clk);
    end
    wr_valid = 1'b0;
  endtask

  task automatic run_cmd(input otp_op_e op, input logic [23:0] a, input int n);
    int k;
    rx_q = {};
    k = 0;
    while (cmd_ready !== 1'b1 && k < LIM) begin
      @(negedge clk);
      k++;
    end
    if (k >= LIM) timeout();
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_addr = a;
    cmd_len = 9'(n);
    @(negedge clk);
    cmd_valid = 1'b0;
    k = 0;
    while (done !== 1'b1 && k < LIM) begin
      if (rd_valid === 1'b1) rx_q.push_back(rd_data);
      @(negedge clk);
      k++;
    end
    if (k >= LIM) timeout();
  endtask

  task automatic wait_idle();
    int k;
    k = 0;
    while (busy !== 1'b0 && k < LIM) begin
      @(negedge clk);
      k++;
    end
    if (k >= LIM) timeout();
  endtask

  task automatic check_read(input logic [9:0] a, input int n);
    run_cmd(OTP_OP_READ, {14'h0, a}, n);
    `TB_CHK(rx_q.size(), n)
    for (int i = 0; i < n; i++) `TB_CHK(rx_q[i], mem[10'(a + i)])
  endtask

  task automatic prog(input logic [9:0] a, input int n, input int base,
                      input logic upd);
    push_many(base, n);
    run_cmd(OTP_OP_PROG, {14'h0, a}, n);
    for (int i = 0; i < n; i++) begin
      if (upd) mem[{a[9:8], 8'(a[7:0] + i)}] &= pat(base + i);
    end
    wait_idle();
  endtask

  initial begin
    int k;
    srst = 1'b1;
    cmd_valid = 1'b0;
    cmd_op = OTP_OP_WR_ENABLE;
    cmd_addr = 24'h0;
    cmd_len = 9'h0;
    wr_valid = 1'b0;
    wr_data = 8'h0;
    lock = 1'b0;
    foreach (mem[i]) mem[i] = 8'hff;
    repeat (20) @(negedge clk);
    srst = 1'b0;
    k = 0;
    while (cmd_ready !== 1'b1 && k < 100) begin
      @(negedge clk);
      k++;
    end
    if (k >= 100) timeout();
    `TB_CHK(k, PU_CYCLES)
    `TB_CHK(busy, 1'b0)
    `TB_CHK(latch, 1'b0)
    run_cmd(OTP_OP_STATUS, 24'h0, 1);
    `TB_CHK(rx_q[0], 8'h00)
    check_read(10'h000, 4);
    $display("test delivered state done");
    push_many(0, 32);
    @(negedge clk);
    `TB_CHK(wr_ready, 1'b0)
    fork
      run_cmd(OTP_OP_PROG, 24'h0, 33);
      begin
        repeat (3000) @(negedge clk);
        push_many(32, 1);
      end
    join
    for (int i = 0; i < 33; i++) mem[i] &= pat(i);
    run_cmd(OTP_OP_STATUS, 24'h0, 1);
    `TB_CHK(rx_q[0], 8'h01)
    wait_idle();
    `TB_CHK(latch, 1'b0)
    check_read(10'h000, 33);
    $display("test long program done");
    prog(10'h001, 2, 100, 1'b1);
    prog(10'h3ff, 3, 200, 1'b1);
    check_read(10'h3fe, 6);
    check_read(10'h2ff, 3);
    run_cmd(OTP_OP_WR_ENABLE, 24'h0, 1);
    `TB_CHK(latch, 1'b1)
    run_cmd(OTP_OP_STATUS, 24'h0, 1);
    `TB_CHK(rx_q[0], 8'h02)
    $display("test reprogram and wrap done");
    lock = 1'b1;
    prog(10'h2ff, 1, 0, 1'b0);
    `TB_CHK(busy, 1'b0)
    run_cmd(OTP_OP_STATUS, 24'h0, 1);
    `TB_CHK(rx_q[0], 8'h06)
    lock = 1'b0;
    check_read(10'h2fe, 3);
    $display("test lock done");
    end_of_test();
  end
endmodule
`default_nettype wire
